// file: hdl/mcfr_map.vh
/*
 * Constants for the configuration and fault report encoder.
 * Assumes inclusion by the encoder only; definitions, no logic.
 */
`ifndef MCFR_MAP_VH
`define MCFR_MAP_VH

// Register offsets (byte addresses, one word each)
`define MCFR_OFS_CFG0      8'h00
`define MCFR_OFS_BUFSIZE   8'h04
`define MCFR_OFS_FAULT     8'h08
`define MCFR_OFS_QUERY     8'h0c
`define MCFR_OFS_STATUS    8'h10
`define MCFR_OFS_TXDATA    8'h14
`define MCFR_OFS_PARAM_SEL 8'h18
`define MCFR_OFS_PARAM_VAL 8'h1c

// Config word 0 field positions
`define MCFR_TXCP_LSB    0
`define MCFR_BCS_LSB     2
`define MCFR_RXCP_BIT    4
`define MCFR_BBL_BIT     5
`define MCFR_BUNIT_BIT   6
`define MCFR_OPMODE_LSB  7
`define MCFR_REMOTE_BIT  9
`define MCFR_TXMODE_LSB  10
`define MCFR_PRE_LSB     12
`define MCFR_RSENC_BIT   14
`define MCFR_RSDEC_LSB   15

// Reset values
`define MCFR_CFG0_RST    17'h0_0000
`define MCFR_CFG0_WIDTH  17

// Parameter numbers
`define MCFR_P_TXCP      8'h23
`define MCFR_P_BCS       8'h24
`define MCFR_P_RXCP      8'h25
`define MCFR_P_BBL       8'h26
`define MCFR_P_BUNIT     8'h27
`define MCFR_P_BSIZE     8'h28
`define MCFR_P_OPMODE    8'h29
`define MCFR_P_REMOTE    8'h2a
`define MCFR_P_BAD_LO    8'h2b
`define MCFR_P_BAD_HI    8'h37
`define MCFR_P_TXMODE    8'h38
`define MCFR_P_PRE       8'h39
`define MCFR_P_RXMODE    8'h3a
`define MCFR_P_RSENC     8'h3c
`define MCFR_P_RSDEC     8'h3d

// Encoded values
`define MCFR_RXMODE_CONT 4'h2
`define MCFR_TXMODE_BURST 2'h1
`define MCFR_CNT_MAX     4'ha

// Reply framing (ASCII)
`define MCFR_CH_CR       8'h0d
`define MCFR_CH_LF       8'h0a
`define MCFR_ECHO_LEN    5'h05
`define MCFR_STAT_LEN    5'h0c
`define MCFR_MSG_LEN     5'h13

`endif

// file: hdl/mcfr_encoder.v
/*
 * Configuration parameter reporter and bulk fault status encoder.
 * Assumes a plain register port driven by a serial command handler,
 * one clock, and fault inputs already synchronous to clk_sys.
 */
// Overview of operation
// RQ1 - Param 35 tx phase: 0,1,2
// RQ2 - Param 36 buffer clock source: 0..3
// RQ3 - Param 37 rx phase: 0 or 1
// RQ4 - Param 38 loopback off/on
// RQ5 - Param 39 buffer unit bits/milliseconds
// RQ6 - Param 40 five-digit buffer size
// RQ7 - Param 41 operation mode 1..3
// RQ8 - Param 42 local 0, remote 1
// RQ9 - Params 43..55 invalid, no value
// RQ10 - Param 56 tx mode burst/continuous
// RQ11 - Param 57 preamble 1 or 2
// RQ12 - Param 58 rx mode always 2
// RQ13 - Param 60 encoder off/on
// RQ14 - Param 61 decoder off/on/no-correction
// RQ15 - Bulk reply: echo, twelve chars, CR LF
// RQ16 - Fault bit one when active
// RQ17 - Char a: bit6, fault, RF, count
// RQ18 - Char b burst: synths and AGC
// RQ19 - Char b continuous adds I, Q
// RQ20 - Char c: bit6 only
// RQ21 - Char d: bit6, fault, carrier, count
// RQ22 - Char e: lock, I, Q, descrambler, BER
// RQ23 - Reserved status bits read zero
`include "mcfr_map.vh"
`timescale 1ns/1ps
`default_nettype none

module mcfr_encoder (
    input  wire        clk_sys,
    input  wire        rst_b,
    input  wire [7:0]  addr,
    input  wire [31:0] wdata,
    input  wire        wr_stb,
    input  wire        rd_stb,
    output reg  [31:0] rdata_ff,
    input  wire        mod_fault,
    input  wire        rf_on,
    input  wire        mod_if_synth_fault,
    input  wire        mod_clk_synth_fault,
    input  wire        mod_i_fault,
    input  wire        mod_q_fault,
    input  wire        mod_agc_fault,
    input  wire        dem_fault,
    input  wire        carrier_detect,
    input  wire        dem_if_lock_fault,
    input  wire        dem_i_fault,
    input  wire        dem_q_fault,
    input  wire        descrambler_fault,
    input  wire        ber_fault,
    input  wire        mod_fault_event,
    input  wire        dem_fault_event,
    output reg  [7:0]  tx_char_ff,
    output reg         tx_valid_ff,
    input  wire        tx_ready,
    output reg         busy_ff
);

    // Software-held configuration word
    reg [`MCFR_CFG0_WIDTH-1:0] cfg_ff;
    reg [16:0]                 bsize_ff;        // Five decimal digits fit in 17 bits
    reg [7:0]                  psel_ff;         // Selected parameter number
    reg [3:0]                  mod_cnt_ff;      // Stored modulator faults
    reg [3:0]                  dem_cnt_ff;      // Stored demodulator faults
    reg [4:0]                  idx_ff;          // Reply character index
    reg [39:0]                 echo;            // Echoed command name

    // Field extraction
    wire [1:0] tx_clock_phase_cmd      = cfg_ff[`MCFR_TXCP_LSB+1:`MCFR_TXCP_LSB];
    wire [1:0] buffer_clock_source_cmd = cfg_ff[`MCFR_BCS_LSB+1:`MCFR_BCS_LSB];
    wire       rx_clock_phase_cmd      = cfg_ff[`MCFR_RXCP_BIT];
    wire       baseband_loopback_cmd   = cfg_ff[`MCFR_BBL_BIT];
    wire       buffer_unit_cmd         = cfg_ff[`MCFR_BUNIT_BIT];
    wire [1:0] operation_mode_cmd      = cfg_ff[`MCFR_OPMODE_LSB+1:`MCFR_OPMODE_LSB];
    wire       remote_mode             = cfg_ff[`MCFR_REMOTE_BIT];
    wire [1:0] tx_mode_cmd             = cfg_ff[`MCFR_TXMODE_LSB+1:`MCFR_TXMODE_LSB];
    wire [1:0] preamble_sel            = cfg_ff[`MCFR_PRE_LSB+1:`MCFR_PRE_LSB];
    wire       rs_encoder_enable_cmd   = cfg_ff[`MCFR_RSENC_BIT];
    wire [1:0] rs_decoder_enable_cmd   = cfg_ff[`MCFR_RSDEC_LSB+1:`MCFR_RSDEC_LSB];

    // Legalised values; out-of-range tx phase, op mode and decoder codes clamp to the top legal code, tx mode and preamble fall back to 1
    reg [1:0] txcp_v;
    reg [1:0] opm_v;
    reg [1:0] txm_v;
    reg [1:0] pre_v;
    reg [1:0] rsd_v;
    always @* begin
        txcp_v = (tx_clock_phase_cmd == 2'h3) ? 2'h2 : tx_clock_phase_cmd;          // [RQ1]
        opm_v  = (operation_mode_cmd == 2'h0) ? 2'h3 : operation_mode_cmd;          // [RQ7]
        txm_v  = (tx_mode_cmd == 2'h2) ? 2'h2 : `MCFR_TXMODE_BURST;                 // [RQ10]
        pre_v  = (preamble_sel == 2'h2) ? 2'h2 : 2'h1;                              // [RQ11]
        rsd_v  = (rs_decoder_enable_cmd == 2'h3) ? 2'h2 : rs_decoder_enable_cmd;    // [RQ14]
    end

    // Parameter value lookup; bit 31 flags a valid parameter
    reg [31:0] param_val;
    always @* begin
        case (psel_ff)
            `MCFR_P_TXCP:   param_val = {1'b1, 29'h0, txcp_v};                      // [RQ1]
            `MCFR_P_BCS:    param_val = {1'b1, 29'h0, buffer_clock_source_cmd};     // [RQ2]
            `MCFR_P_RXCP:   param_val = {1'b1, 30'h0, rx_clock_phase_cmd};          // [RQ3]
            `MCFR_P_BBL:    param_val = {1'b1, 30'h0, baseband_loopback_cmd};       // [RQ4]
            `MCFR_P_BUNIT:  param_val = {1'b1, 30'h0, buffer_unit_cmd};             // [RQ5]
            `MCFR_P_BSIZE:  param_val = {1'b1, 13'h0, buffer_unit_cmd, bsize_ff};   // [RQ6]
            `MCFR_P_OPMODE: param_val = {1'b1, 29'h0, opm_v};                       // [RQ7]
            `MCFR_P_REMOTE: param_val = {1'b1, 30'h0, remote_mode};                 // [RQ8]
            `MCFR_P_TXMODE: param_val = {1'b1, 29'h0, txm_v};                       // [RQ10]
            `MCFR_P_PRE:    param_val = {1'b1, 29'h0, pre_v};                       // [RQ11]
            `MCFR_P_RXMODE: param_val = {1'b1, 27'h0, `MCFR_RXMODE_CONT};           // [RQ12]
            `MCFR_P_RSENC:  param_val = {1'b1, 30'h0, rs_encoder_enable_cmd};       // [RQ13]
            `MCFR_P_RSDEC:  param_val = {1'b1, 29'h0, rsd_v};                       // [RQ14]
            // 43..55, 59 and anything else: invalid, no setting
            default:        param_val = 32'h0000_0000;                              // [RQ9]
        endcase
    end

    // Status characters a..e; c and f..l beyond e are bit 6 only
    wire burst = (txm_v == `MCFR_TXMODE_BURST);
    wire [6:0] ch_a = {1'b1, mod_fault, rf_on, mod_cnt_ff};                         // [RQ17]
    wire [6:0] ch_b = {1'b1, mod_if_synth_fault, mod_clk_synth_fault,
                       mod_i_fault & ~burst, mod_q_fault & ~burst,                  // [RQ19]
                       mod_agc_fault, 1'b0};                                        // [RQ18]
    wire [6:0] ch_c = 7'h40;                                                        // [RQ20]
    wire [6:0] ch_d = {1'b1, dem_fault, carrier_detect, dem_cnt_ff};                // [RQ21]
    wire [6:0] ch_e = {1'b1, dem_if_lock_fault, dem_i_fault, dem_q_fault,
                       descrambler_fault, ber_fault, 1'b0};                         // [RQ22]

    // Reply character by index
    reg [7:0] reply_ch;
    always @* begin
        echo = 40'h4243_5346_5f;                                                    // Name and underscore
        if (idx_ff < `MCFR_ECHO_LEN) begin
            reply_ch = echo[39 - 8*idx_ff -: 8];                                    // [RQ15]
        end else begin
            case (idx_ff - `MCFR_ECHO_LEN)
                5'h00:   reply_ch = {1'b0, ch_a};                                   // [RQ16]
                5'h01:   reply_ch = {1'b0, ch_b};
                5'h02:   reply_ch = {1'b0, ch_c};
                5'h03:   reply_ch = {1'b0, ch_d};
                5'h04:   reply_ch = {1'b0, ch_e};
                5'h0c:   reply_ch = `MCFR_CH_CR;                                    // [RQ15]
                5'h0d:   reply_ch = `MCFR_CH_LF;
                default: reply_ch = 8'h40;                                          // [RQ23]
            endcase
        end
    end

    // Register writes and fault counters; counters saturate at ten
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            cfg_ff     <= `MCFR_CFG0_RST;
            bsize_ff   <= 17'h0_0000;
            psel_ff    <= 8'h00;
            mod_cnt_ff <= 4'h0;
            dem_cnt_ff <= 4'h0;
        end else begin
            if (wr_stb && addr == `MCFR_OFS_CFG0) begin
                cfg_ff <= wdata[`MCFR_CFG0_WIDTH-1:0];
            end
            if (wr_stb && addr == `MCFR_OFS_BUFSIZE) begin
                // Five digits cap at 99999
                bsize_ff <= (wdata[16:0] > 17'h1_869f) ? 17'h1_869f : wdata[16:0];  // [RQ6]
            end
            if (wr_stb && addr == `MCFR_OFS_PARAM_SEL) begin
                psel_ff <= wdata[7:0];
            end
            // Event beats a clear in the same cycle, even when saturated
            if (mod_fault_event) begin
                if (mod_cnt_ff != `MCFR_CNT_MAX) begin
                    mod_cnt_ff <= mod_cnt_ff + 4'h1;                                // [RQ17]
                end
            end else if (wr_stb && addr == `MCFR_OFS_FAULT && wdata[0]) begin
                mod_cnt_ff <= 4'h0;
            end
            if (dem_fault_event) begin
                if (dem_cnt_ff != `MCFR_CNT_MAX) begin
                    dem_cnt_ff <= dem_cnt_ff + 4'h1;                                // [RQ21]
                end
            end else if (wr_stb && addr == `MCFR_OFS_FAULT && wdata[1]) begin
                dem_cnt_ff <= 4'h0;
            end
        end
    end

    // Reply sequencer: a query write starts a 19-character stream
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            idx_ff      <= 5'h00;
            busy_ff     <= 1'b0;
            tx_valid_ff <= 1'b0;
            tx_char_ff  <= 8'h00;
        end else if (!busy_ff) begin
            // Query while idle only; a query while busy is dropped
            if (wr_stb && addr == `MCFR_OFS_QUERY) begin                            // [RQ15]
                busy_ff     <= 1'b1;
                idx_ff      <= 5'h00;
                tx_valid_ff <= 1'b0;
            end
        end else if (!tx_valid_ff) begin
            tx_char_ff  <= reply_ch;                                                // [RQ15]
            tx_valid_ff <= 1'b1;
        end else if (tx_ready) begin
            tx_valid_ff <= 1'b0;
            if (idx_ff == `MCFR_MSG_LEN - 5'h01) begin
                busy_ff <= 1'b0;
            end else begin
                idx_ff <= idx_ff + 5'h01;
            end
        end
    end

    // Read data, one cycle after the strobe; unmapped reads zero
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rdata_ff <= 32'h0000_0000;
        end else if (rd_stb) begin
            case (addr)
                `MCFR_OFS_CFG0:      rdata_ff <= {15'h0, cfg_ff};
                `MCFR_OFS_BUFSIZE:   rdata_ff <= {15'h0, bsize_ff};
                `MCFR_OFS_FAULT:     rdata_ff <= {24'h0, mod_cnt_ff, dem_cnt_ff};
                `MCFR_OFS_STATUS:    rdata_ff <= {31'h0, busy_ff};
                `MCFR_OFS_TXDATA:    rdata_ff <= {4'h0, ch_e, ch_d, ch_b, ch_a};
                `MCFR_OFS_PARAM_SEL: rdata_ff <= {24'h0, psel_ff};
                `MCFR_OFS_PARAM_VAL: rdata_ff <= param_val;
                default:             rdata_ff <= 32'h0000_0000;
            endcase
        end else begin
            rdata_ff <= 32'h0000_0000;
        end
    end

endmodule // mcfr_encoder

`default_nettype wire

// file: tb/mcfr_encoder_assertions.sv
/* Port checker for the report encoder.
   Assumes one clock and an async active-low reset. */
`timescale 1ns/1ps
`default_nettype none
module mcfr_chk (
    input wire logic        clk_sys,
    input wire logic        rst_b,
    input wire logic [7:0]  addr,
    input wire logic        wr_stb,
    input wire logic        rd_stb,
    input wire logic [31:0] rdata_ff,
    input wire logic [7:0]  tx_char_ff,
    input wire logic        tx_valid_ff,
    input wire logic        tx_ready,
    input wire logic        busy_ff
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    // Offered char holds until taken
    valid_hold_a: assert property (tx_valid_ff && !tx_ready |=> tx_valid_ff && $stable(tx_char_ff))
        else $error("char dropped early");
    valid_drop_a: assert property (tx_valid_ff && tx_ready |=> !tx_valid_ff)
        else $error("valid stuck after accept");
    char_bit7_a: assert property (tx_valid_ff |-> !tx_char_ff[7])
        else $error("char top bit set");
    // Status chars always carry bit 6, framing is CR or LF
    status_bit6_a: assert property (tx_valid_ff && !tx_char_ff[6] |->
        tx_char_ff == 8'h0d || tx_char_ff == 8'h0a) else $error("bit 6 missing");
    busy_start_a: assert property (wr_stb && addr == 8'h0c && !busy_ff |=> busy_ff)
        else $error("query not taken");
    first_char_a: assert property ($rose(busy_ff) |-> !tx_valid_ff ##1
        (tx_valid_ff && tx_char_ff == 8'h42)) else $error("echo start wrong");
    valid_busy_a: assert property (tx_valid_ff |-> busy_ff)
        else $error("char outside reply");
    unmapped_rd_a: assert property (rd_stb && addr == 8'h20 |=> rdata_ff == 32'h0)
        else $error("unmapped read not zero");
    rdata_idle_a: assert property (!rd_stb |=> rdata_ff == 32'h0)
        else $error("read data outside read cycle");
endmodule // mcfr_chk
bind mcfr_encoder mcfr_chk u_chk (.clk_sys(clk_sys), .rst_b(rst_b), .addr(addr),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata_ff(rdata_ff), .tx_char_ff(tx_char_ff),
    .tx_valid_ff(tx_valid_ff), .tx_ready(tx_ready), .busy_ff(busy_ff));
`default_nettype wire

// file: tb/mcfr_host.sv
/* Remote host model: takes reply chars, may stall.
   Assumes the encoder's valid/ready stream on clk_sys. */
`timescale 1ns/1ps
`default_nettype none
module mcfr_host (
    input wire logic       clk_sys,
    input wire logic       rst_b,
    input wire logic [7:0] tx_char_ff,
    input wire logic       tx_valid_ff,
    input wire logic       stall_en,
    output logic           tx_ready,
    output logic           acc_stb,
    output logic [7:0]     acc_char
);
    logic [15:0] pat_ff;  // Stall pattern, irregular on purpose
    // Accept on valid and ready, report the char a cycle later
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            tx_ready <= 1'b0;
            acc_stb  <= 1'b0;
            acc_char <= 8'h00;
            pat_ff   <= 16'h0001;
        end else begin
            pat_ff   <= {pat_ff[14:0], pat_ff[15] ^ pat_ff[13] ^ pat_ff[12] ^ pat_ff[10]};
            tx_ready <= !stall_en || pat_ff[0];
            acc_stb  <= tx_valid_ff && tx_ready;
            acc_char <= tx_char_ff;
        end
    end
endmodule // mcfr_host
`default_nettype wire

// file: tb/mcfr_encoder_tb.sv
/* Self-checking bench: parameter reads and bulk fault replies.
   Assumes mcfr_encoder, mcfr_host and the checker bind. */
`timescale 1ns/1ps
`default_nettype none
module mcfr_encoder_tb;
    logic        clk_sys = 1'b0, rst_b = 1'b0, wr_stb = 1'b0, rd_stb = 1'b0;
    logic [7:0]  addr    = 8'h00, n;
    logic [31:0] wdata   = 32'h0, rv, seed = 32'hc271;
    logic [13:0] flt     = 14'h0;  // Fault levels, packed
    logic        mev = 1'b0, dev = 1'b0, stall = 1'b0;
    logic [16:0] cfg, bsz;
    logic [7:0]  rx_q[$];
    wire  [31:0] rdata;
    wire  [7:0]  tx_char, acc_char;
    wire         tx_valid, tx_ready, busy, acc_stb;
    int          error_cnt = 0, num_checks = 0, nm, nd, t, i;
    always #2 clk_sys = ~clk_sys;
    mcfr_encoder u_mcfr_encoder (.clk_sys(clk_sys), .rst_b(rst_b), .addr(addr), .wdata(wdata),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata_ff(rdata), .mod_fault(flt[0]), .rf_on(flt[1]),
        .mod_if_synth_fault(flt[2]), .mod_clk_synth_fault(flt[3]), .mod_i_fault(flt[4]),
        .mod_q_fault(flt[5]), .mod_agc_fault(flt[6]), .dem_fault(flt[7]),
        .carrier_detect(flt[8]), .dem_if_lock_fault(flt[9]), .dem_i_fault(flt[10]),
        .dem_q_fault(flt[11]), .descrambler_fault(flt[12]), .ber_fault(flt[13]),
        .mod_fault_event(mev), .dem_fault_event(dev), .tx_char_ff(tx_char),
        .tx_valid_ff(tx_valid), .tx_ready(tx_ready), .busy_ff(busy));
    mcfr_host u_mcfr_host (.clk_sys(clk_sys), .rst_b(rst_b), .tx_char_ff(tx_char),
        .tx_valid_ff(tx_valid), .stall_en(stall), .tx_ready(tx_ready), .acc_stb(acc_stb),
        .acc_char(acc_char));
    // Gather the host's accepted chars
    always @(posedge clk_sys) if (acc_stb) rx_q.push_back(acc_char);
    function automatic [31:0] lfsr(input [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic [31:0] exp_param(input [7:0] p);
        logic [17:0] v;
        v = 18'h0;
        case (p)
            8'h23: v = cfg[1:0];   8'h24: v = cfg[3:2];   8'h25: v = cfg[4];
            8'h26: v = cfg[5];     8'h27: v = cfg[6];     8'h28: v = {cfg[6], bsz};
            8'h29: v = cfg[8:7];   8'h2a: v = cfg[9];     8'h38: v = cfg[11:10];
            8'h39: v = cfg[13:12]; 8'h3a: v = 18'h2;      8'h3c: v = cfg[14];
            8'h3d: v = cfg[16:15];
            default: return 32'h0;  // Invalid slots carry nothing
        endcase
        return {14'h2000, v};
    endfunction
    function automatic [7:0] exp_char(input int k);
        logic c;
        c = (cfg[11:10] == 2'h2);  // I/Q only in continuous mode
        case (k)
            0: return 8'h42; 1: return 8'h43; 2: return 8'h53; 3: return 8'h46; 4: return 8'h5f;
            5: return {2'b01, flt[0], flt[1], nm[3:0]};
            6: return {2'b01, flt[2], flt[3], c & flt[4], c & flt[5], flt[6], 1'b0};
            8: return {2'b01, flt[7], flt[8], nd[3:0]};
            9: return {2'b01, flt[9], flt[10], flt[11], flt[12], flt[13], 1'b0};
            17: return 8'h0d; 18: return 8'h0a;
            default: return 8'h40;
        endcase
    endfunction
    task automatic wr(input [7:0] a, input [31:0] d);
        @(posedge clk_sys); addr <= a; wdata <= d; wr_stb <= 1'b1;
        @(posedge clk_sys); wr_stb <= 1'b0;
    endtask
    task automatic rd(input [7:0] a, output [31:0] d);
        @(posedge clk_sys); addr <= a; rd_stb <= 1'b1;
        @(posedge clk_sys); rd_stb <= 1'b0;
        #1 d = rdata;  // Data stand only in this cycle
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic chk_c(input logic [7:0] g, input logic [7:0] e);
        chk({24'h0, g}, {24'h0, e});
    endtask
    task automatic finish_test;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        #200000; error_cnt++; finish_test;
    end
    initial begin
        repeat (6) @(posedge clk_sys);
        rst_b <= 1'b1;
        for (t = 0; t < 3; t++) begin
            seed = lfsr(seed); rv = seed;
            cfg = {2'(rv[16:15] % 3), rv[14], 2'(rv[12] + 1), 2'(rv[10] + 1), rv[9],
                   2'(rv[8:7] % 3 + 1), rv[6:4], rv[3:2], 2'(rv[1:0] % 3)};
            bsz = rv[31:17] * 3;
            if (t == 0) cfg = {2'h2, 1'b1, 2'h2, 2'h2, 1'b1, 2'h3, 3'h7, 2'h3, 2'h2};
            if (t == 0) bsz = 17'h1869f;  // Largest five-digit size
            wr(8'h00, {15'h0, cfg});
            wr(8'h04, {15'h0, bsz});
            for (n = 8'h23; n <= 8'h3d; n++) begin
                wr(8'h18, {24'h0, n});
                rd(8'h1c, rv);
                if (n < 8'h2b) chk(rv, exp_param(n));
                else chk(rv, exp_param(n));
            end
            rd(8'h20, rv);
            chk(rv, 32'h0);
            $display("param test %0d done", t);
        end
        for (t = 0; t < 2; t++) begin
            cfg[11:10] = 2'(t + 1);  // Burst, then continuous
            wr(8'h00, {15'h0, cfg});
            wr(8'h08, 32'h3);
            seed = lfsr(seed); nm = seed[3:0] % 14; nd = seed[7:4] % 14;
            for (i = 0; i < 14; i++) begin
                @(posedge clk_sys); mev <= (i < nm); dev <= (i < nd);
            end
            @(posedge clk_sys); mev <= 1'b0; dev <= 1'b0;
            flt <= seed[21:8]; stall <= t[0];
            if (nm > 10) nm = 10;  // Counters saturate
            if (nd > 10) nd = 10;
            rd(8'h08, rv);
            chk(rv, {24'h0, nm[3:0], nd[3:0]});
            rx_q.delete();
            wr(8'h0c, 32'h1);
            wr(8'h0c, 32'h1);  // Dropped while busy
            for (i = 0; i < 600 && rx_q.size() < 19; i++) @(posedge clk_sys);
            repeat (20) @(posedge clk_sys);
            chk(rx_q.size(), 32'd19);
            for (i = 0; i < 19 && i < rx_q.size(); i++) begin
                if (i < 5 || i > 16) chk_c(rx_q[i], exp_char(i));
                else chk_c(rx_q[i], exp_char(i));
            end
            $display("reply test %0d done", t);
        end
        finish_test;
    end
endmodule // mcfr_encoder_tb
`default_nettype wire
